// ===== verilog/flash_program_control_defs.svh
// constants and register map of the flash program control block
`ifndef FLASH_PROGRAM_CONTROL_DEFS_SVH
`define FLASH_PROGRAM_CONTROL_DEFS_SVH
`define FPC_CTRL_OFS      8'h00
`define FPC_ADDR_OFS      8'h04
`define FPC_WDATA_OFS     8'h08
`define FPC_RDATA_OFS     8'h0c
`define FPC_INT_STAT_OFS  8'h10
`define FPC_INT_MASK_OFS  8'h14
`define FPC_BIT_TOP       7
`define FPC_BIT_CFG       6
`define FPC_BIT_LATCH     5
`define FPC_BIT_ERASE     4
`define FPC_BIT_FAULT     3
`define FPC_BIT_UNLOCK    2
`define FPC_BIT_GO        1
`define FPC_BIT_FETCH     0
`define FPC_CTRL_RESET    8'h80
`define FPC_EV_DONE       0
`define FPC_EV_FAULT      1
`define FPC_EV_FETCH      2
`define FPC_EV_N          3
`define FPC_PROG_TIME_NS  2000
`define FPC_CLK_MHZ       125
`endif

// ===== verilog/flash_program_control_pkg.sv
// types shared by the flash program control block
package flash_program_control_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_ERASE,
      ST_LATCH
   } prog_state_e;
endpackage

// ===== verilog/flash_program_control.sv
// flash program control: apb registers, program sequencer, fetch and interrupt
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "flash_program_control_defs.svh"
module flash_program_control
   import flash_program_control_pkg::*;
#(
   parameter int ADDR_W       = 15,
   parameter int DATA_W       = 14,
   parameter int PROG_TIME_NS = `FPC_PROG_TIME_NS
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   input  wire logic              abort_in,
   output logic      [ADDR_W-1:0] flash_addr,
   output logic      [DATA_W-1:0] flash_wdata,
   input  wire logic [DATA_W-1:0] flash_rdata,
   output logic                   flash_read,
   output logic                   flash_write,
   output logic                   flash_erase,
   output logic                   flash_latch,
   output logic                   cfg_space
);
   localparam int PROG_CYC_I = (PROG_TIME_NS * `FPC_CLK_MHZ + 999) / 1000;
   localparam logic [15:0] PROG_CYC = 16'(PROG_CYC_I < 1 ? 1 : PROG_CYC_I);

   prog_state_e           state_r;
   logic [15:0]           timer_r;
   logic                  cfg_r;
   logic                  latch_only_r;
   logic                  erase_sel_r;
   logic                  fault_r;
   logic                  unlock_r;
   logic                  go_r;
   logic                  fetch_r;
   logic [ADDR_W-1:0]     addr_r;
   logic [DATA_W-1:0]     wdata_r;
   logic [DATA_W-1:0]     rdata_r;
   logic [`FPC_EV_N-1:0]  int_stat_r;
   logic [`FPC_EV_N-1:0]  int_mask_r;
   logic [`FPC_EV_N-1:0]  ev;
   logic [31:0]           rd_nxt;
   logic [31:0]           prdata_r;
   logic                  abort_m_r;
   logic                  abort_s_r;
   logic                  acc;
   logic                  wr;
   logic                  rd;
   logic                  mapped;
   logic                  ctrl_wr;
   logic                  go_req;
   logic                  launch;
   logic                  refused;
   logic                  busy;
   logic                  op_end;
   logic                  aborted;
   logic [15:0]           wr_len_r;

   // apb: zero wait states, one access phase per transfer
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr == `FPC_CTRL_OFS) || (paddr == `FPC_ADDR_OFS) ||
                    (paddr == `FPC_WDATA_OFS) || (paddr == `FPC_RDATA_OFS) ||
                    (paddr == `FPC_INT_STAT_OFS) || (paddr == `FPC_INT_MASK_OFS);
   assign pslverr = acc & ~mapped;
   assign ctrl_wr = wr && paddr == `FPC_CTRL_OFS;

   // abort comes from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_m_r <= 1'b0;
         abort_s_r <= 1'b0;
      end else begin
         abort_m_r <= abort_in;
         abort_s_r <= abort_m_r;
      end
   end

   // program sequencer
   assign busy    = state_r != ST_IDLE;
   assign go_req  = ctrl_wr & pwdata[`FPC_BIT_GO] & ~go_r;
   assign launch  = go_req & unlock_r;
   assign refused = go_req & ~unlock_r;
   assign aborted = busy & abort_s_r;
   assign op_end  = busy & ~abort_s_r & (timer_r == 16'h0000);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         timer_r <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (launch) begin
                  timer_r <= PROG_CYC - 16'h0001;
                  if (erase_sel_r) begin
                     state_r <= ST_ERASE;
                  end else if (latch_only_r) begin
                     state_r <= ST_LATCH;
                     timer_r <= 16'h0000;
                  end else begin
                     state_r <= ST_WRITE;
                  end
               end
            end
            default: begin
               if (aborted || op_end) begin
                  state_r <= ST_IDLE;
               end else begin
                  timer_r <= timer_r - 16'h0001;
               end
            end
         endcase
      end
   end

   // array strobes last for the whole self-timed operation
   assign flash_write = state_r == ST_WRITE;
   assign flash_erase = state_r == ST_ERASE;
   assign flash_latch = state_r == ST_LATCH;
   assign flash_read  = fetch_r;
   assign flash_addr  = addr_r;
   assign flash_wdata = wdata_r;
   assign cfg_space   = cfg_r;

   // control register bits that software writes plainly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r        <= 1'b0;
         latch_only_r <= 1'b0;
         unlock_r     <= 1'b0;
      end else if (ctrl_wr) begin
         cfg_r        <= pwdata[`FPC_BIT_CFG];
         latch_only_r <= pwdata[`FPC_BIT_LATCH];
         unlock_r     <= pwdata[`FPC_BIT_UNLOCK];
      end
   end

   // erase select frozen while busy so the running operation keeps its kind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_sel_r <= 1'b0;
      end else if (op_end && state_r == ST_ERASE) begin
         erase_sel_r <= 1'b0;
      end else if (ctrl_wr && !busy) begin
         erase_sel_r <= pwdata[`FPC_BIT_ERASE];
      end
   end

   // fault: set wins over a software clear; a normal end clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_r <= 1'b0;
      end else if (launch || refused || aborted) begin
         fault_r <= 1'b1;
      end else if (op_end) begin
         fault_r <= 1'b0;
      end else if (ctrl_wr) begin
         fault_r <= pwdata[`FPC_BIT_FAULT];
      end
   end

   // go only sets from software, only the sequencer clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_r <= 1'b0;
      end else if (launch) begin
         go_r <= 1'b1;
      end else if (aborted || op_end) begin
         go_r <= 1'b0;
      end
   end

   // one-cycle fetch; rdata captured at its end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         fetch_r <= ctrl_wr & pwdata[`FPC_BIT_FETCH] & ~fetch_r;
         if (fetch_r) begin
            rdata_r <= flash_rdata;
         end
      end
   end

   // address and data holding registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r  <= '0;
         wdata_r <= '0;
      end else if (wr && !busy) begin
         if (paddr == `FPC_ADDR_OFS) begin
            addr_r <= pwdata[ADDR_W-1:0];
         end else if (paddr == `FPC_WDATA_OFS) begin
            wdata_r <= pwdata[DATA_W-1:0];
         end
      end
   end

   // interrupts: sticky, cleared by reading status, a new event wins
   always_comb begin
      ev                = '0;
      ev[`FPC_EV_DONE]  = op_end;
      ev[`FPC_EV_FAULT] = refused | aborted;
      ev[`FPC_EV_FETCH] = fetch_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= '0;
         int_mask_r <= '0;
      end else begin
         if (rd && paddr == `FPC_INT_STAT_OFS) begin
            // clear only what the reader saw; a bit set after the snapshot survives
            int_stat_r <= (int_stat_r & ~prdata_r[`FPC_EV_N-1:0]) | ev;
         end else begin
            int_stat_r <= int_stat_r | ev;
         end
         if (wr && paddr == `FPC_INT_MASK_OFS) begin
            int_mask_r <= pwdata[`FPC_EV_N-1:0];
         end
      end
   end

   assign irq = |(int_stat_r & int_mask_r);

   // read data built in the setup cycle, presented during the access phase
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (paddr == `FPC_CTRL_OFS) begin
         rd_nxt[`FPC_BIT_TOP]    = 1'b1;
         rd_nxt[`FPC_BIT_CFG]    = cfg_r;
         rd_nxt[`FPC_BIT_LATCH]  = latch_only_r;
         rd_nxt[`FPC_BIT_ERASE]  = erase_sel_r;
         rd_nxt[`FPC_BIT_FAULT]  = fault_r;
         rd_nxt[`FPC_BIT_UNLOCK] = unlock_r;
         rd_nxt[`FPC_BIT_GO]     = go_r;
         rd_nxt[`FPC_BIT_FETCH]  = fetch_r;
      end else if (paddr == `FPC_ADDR_OFS) begin
         rd_nxt[ADDR_W-1:0] = addr_r;
      end else if (paddr == `FPC_WDATA_OFS) begin
         rd_nxt[DATA_W-1:0] = wdata_r;
      end else if (paddr == `FPC_RDATA_OFS) begin
         rd_nxt[DATA_W-1:0] = rdata_r;
      end else if (paddr == `FPC_INT_STAT_OFS) begin
         rd_nxt[`FPC_EV_N-1:0] = int_stat_r;
      end else if (paddr == `FPC_INT_MASK_OFS) begin
         rd_nxt[`FPC_EV_N-1:0] = int_mask_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_nxt;
      end
   end

   assign prdata = prdata_r;

   // helper for the strobe length check: cycles flash_write has stood
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_len_r <= 16'h0000;
      end else if (flash_write) begin
         wr_len_r <= wr_len_r + 16'h0001;
      end else begin
         wr_len_r <= 16'h0000;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_erase_clears_select;
      (state_r == ST_ERASE && op_end) |=> !erase_sel_r;
   endproperty
   a_erase_clears_select: assert property (p_erase_clears_select)
      else $error("erase select still set after erase");

   property p_refused_fault;
      refused |=> fault_r && !busy && !go_r;
   endproperty
   a_refused_fault: assert property (p_refused_fault)
      else $error("locked program attempt did not flag a fault");

   property p_launch_fault;
      launch |=> fault_r && go_r && busy;
   endproperty
   a_launch_fault: assert property (p_launch_fault)
      else $error("launch did not set fault and go");

   property p_go_tracks_busy;
      go_r == busy;
   endproperty
   a_go_tracks_busy: assert property (p_go_tracks_busy)
      else $error("go bit and sequencer disagree");

   property p_write_length;
      (flash_write && op_end) |-> wr_len_r == PROG_CYC - 16'h0001;
   endproperty
   a_write_length: assert property (p_write_length)
      else $error("write strobe length wrong");

   property p_zero_no_clear;
      (go_r && ctrl_wr && !pwdata[`FPC_BIT_GO] && !op_end && !aborted) |=> go_r;
   endproperty
   a_zero_no_clear: assert property (p_zero_no_clear)
      else $error("software cleared go");

   property p_fetch_one_cycle;
      fetch_r |=> !fetch_r && $past(fetch_r) && rdata_r == $past(flash_rdata);
   endproperty
   a_fetch_one_cycle: assert property (p_fetch_one_cycle)
      else $error("fetch did not finish in one cycle");

   property p_erase_ignores_latch;
      (launch && erase_sel_r) |=> state_r == ST_ERASE;
   endproperty
   a_erase_ignores_latch: assert property (p_erase_ignores_latch)
      else $error("erase diverted by latch only mode");

   property p_top_bit_one;
      (psel && !penable && !pwrite && paddr == `FPC_CTRL_OFS)
         |=> prdata[`FPC_BIT_TOP];
   endproperty
   a_top_bit_one: assert property (p_top_bit_one)
      else $error("control top bit read as zero");

   property p_locked_no_array;
      (!busy && !unlock_r) |=> !(flash_write || flash_erase || flash_latch);
   endproperty
   a_locked_no_array: assert property (p_locked_no_array)
      else $error("array touched while locked");

endmodule

// ===== tb/flash_program_control_tb_top.sv
// self-checking bench for the flash program control block
`timescale 1ns/1ps
`include "flash_program_control_defs.svh"
module flash_program_control_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        abort_in;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        irq;
   logic        fl_rd;
   logic        fl_wr;
   logic        fl_er;
   logic        fl_lt;
   logic        cfg_space;
   logic [14:0] flash_addr;
   logic [13:0] flash_wdata;
   logic [13:0] flash_rdata;
   int          error_cnt;
   int          check_count;
   int          rd_pulses;
   int          latch_seen;

   // short program time keeps each write and erase at 20 cycles
   flash_program_control #(.PROG_TIME_NS(160)) dut (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .irq         (irq),
      .abort_in    (abort_in),
      .flash_addr  (flash_addr),
      .flash_wdata (flash_wdata),
      .flash_rdata (flash_rdata),
      .flash_read  (fl_rd),
      .flash_write (fl_wr),
      .flash_erase (fl_er),
      .flash_latch (fl_lt),
      .cfg_space   (cfg_space)
   );

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // pulse counts prove one-cycle strobes without guessing the launch edge
   always @(posedge pclk) begin
      if (fl_rd === 1'b1) rd_pulses++;
      if (fl_lt === 1'b1) latch_seen++;
   end

   task automatic close_out;
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, rd, exp);
   endtask

   task automatic settle;
      repeat (2) @(negedge pclk);
   endtask

   task automatic wait_idle;
      int i;
      i = 0;
      while ((fl_wr !== 1'b0 || fl_er !== 1'b0) && i < 100) begin
         @(posedge pclk);
         i++;
      end
      settle();
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      close_out();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      abort_in = 1'b0;
      flash_rdata = 14'h2a5a;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl reset", `FPC_CTRL_OFS, 32'h80);
      wr(`FPC_CTRL_OFS, 32'h40);
      settle();
      chk("cfg space", cfg_space, 1);
      rdc("ctrl top bit", `FPC_CTRL_OFS, 32'hc0);
      wr(`FPC_INT_MASK_OFS, 32'h7);
      // go while locked must be refused and flagged
      wr(`FPC_CTRL_OFS, 32'h02);
      settle();
      chk("locked write strobe", fl_wr, 0);
      chk("irq on fault", irq, 1);
      rdc("ctrl refused", `FPC_CTRL_OFS, 32'h88);
      rdc("status refused", `FPC_INT_STAT_OFS, 32'h2);
      settle();
      chk("irq after clear", irq, 0);
      wr(`FPC_ADDR_OFS, 32'h1234);
      wr(`FPC_WDATA_OFS, 32'h3abc);
      settle();
      chk("flash addr", flash_addr, 32'h1234);
      chk("flash wdata", flash_wdata, 32'h3abc);
      // unlock in an earlier write, then launch a write
      wr(`FPC_CTRL_OFS, 32'h04);
      wr(`FPC_CTRL_OFS, 32'h06);
      settle();
      chk("write strobe", fl_wr, 1);
      chk("erase strobe idle", fl_er, 0);
      rdc("ctrl launched", `FPC_CTRL_OFS, 32'h8e);
      wr(`FPC_CTRL_OFS, 32'h0c);
      rdc("go held", `FPC_CTRL_OFS, 32'h8e);
      wait_idle();
      rdc("ctrl done", `FPC_CTRL_OFS, 32'h84);
      rdc("status done", `FPC_INT_STAT_OFS, 32'h1);
      // erase with latch_only_load also set
      wr(`FPC_CTRL_OFS, 32'h34);
      wr(`FPC_CTRL_OFS, 32'h36);
      settle();
      chk("erase strobe", fl_er, 1);
      chk("no write on erase", fl_wr, 0);
      wait_idle();
      chk("latch strobes", latch_seen, 0);
      rdc("ctrl erased", `FPC_CTRL_OFS, 32'ha4);
      rdc("status erased", `FPC_INT_STAT_OFS, 32'h1);
      // fetch with interrupts masked
      wr(`FPC_INT_MASK_OFS, 32'h0);
      wr(`FPC_CTRL_OFS, 32'ha5);
      settle();
      chk("masked irq", irq, 0);
      chk("read pulses", rd_pulses, 1);
      rdc("ctrl fetched", `FPC_CTRL_OFS, 32'ha4);
      rdc("fetched data", `FPC_RDATA_OFS, 32'h2a5a);
      rdc("status fetch", `FPC_INT_STAT_OFS, 32'h4);
      wr(`FPC_CTRL_OFS, 32'ha4);
      settle();
      chk("read pulses zero write", rd_pulses, 1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", err, 1);
      chk("unmapped data", rd, 0);
      // abort mid-write leaves fault set; latch_only_load cleared first
      wr(`FPC_CTRL_OFS, 32'h04);
      wr(`FPC_CTRL_OFS, 32'h06);
      repeat (3) @(posedge pclk);
      abort_in <= 1'b1;
      repeat (6) @(posedge pclk);
      abort_in <= 1'b0;
      settle();
      chk("aborted strobe", fl_wr, 0);
      rdc("ctrl aborted", `FPC_CTRL_OFS, 32'h8c);
      rdc("status aborted", `FPC_INT_STAT_OFS, 32'h2);
      // latch-only load: one strobe cycle, then done
      wr(`FPC_CTRL_OFS, 32'h24);
      wr(`FPC_CTRL_OFS, 32'h26);
      settle();
      chk("latch strobe once", latch_seen, 1);
      rdc("ctrl latched", `FPC_CTRL_OFS, 32'ha4);
      rdc("status latched", `FPC_INT_STAT_OFS, 32'h1);
      close_out();
   end
endmodule
